// ---- rcpwm_top.sv ----
/*
 rcpwm_top: reload-counter pwm with dither and permille setup.
 lower channels count down from their own preset; upper channels
 share one up counter. assumes a single-cycle register master
 on the system clock; outputs drive valve drivers directly.
*/
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module rcpwm_top import rcpwm_pkg::*; #(
	parameter int NLOW = 4,
	parameter int NUP = 4
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic [NLOW+NUP-1:0] pwm_out
);
	localparam int NCH = NLOW + NUP;

	logic [CTRL_W-1:0] ctrl_q;
	logic [15:0] reload_q [NLOW];
	logic [15:0] up_reload_q;
	logic [31:0] dither_q [NCH];
	logic [NCH-1:0] duty_ld_q;
	logic [15:0] duty_val_q [NCH];
	logic refused_q;
	rcpwm_job_e state_q;
	logic [2:0] job_ch_q;
	logic job_chg_q;
	logic [16:0] job_span_q;
	logic [PSC_W-1:0] psc_q;
	logic psc_tick;

	logic [15:0] low_cnt_q [NLOW];
	logic [15:0] low_rl [NLOW];
	logic [NLOW-1:0] low_run;
	logic [NLOW-1:0] low_tick;
	logic [NLOW-1:0] low_wrap;
	logic [15:0] up_cnt_q;
	logic [15:0] up_rl;
	logic up_run;
	logic up_tick;
	logic up_wrap;

	logic [15:0] ch_cnt [NCH];
	logic [15:0] ch_rl [NCH];
	logic [NCH-1:0] ch_wrap;
	logic [15:0] ch_cmp [NCH];

	logic [2:0] reg_ch;
	logic [2:0] reg_region;
	logic ch_ok;
	logic wr_reload;
	logic wr_freq;
	logic wr_pm;
	logic req_ok;
	logic job_up;
	logic div_start;
	logic div_busy;
	logic div_done;
	logic [31:0] div_num;
	logic [31:0] div_den;
	logic [31:0] div_quot;
	logic [15:0] quot_sat;
	logic [16:0] pm_diff;
	logic [15:0] pm_cmp;
	logic [31:0] rd_mux;

	// shortest span for the selected tick, so frequency stays capped
	function automatic logic [15:0] min_span(input logic psc);
		min_span = psc ? 16'(MIN_SPAN_PS) : 16'(MIN_SPAN);
	endfunction : min_span

	////////////////////////////////////////////////////////////
	// address decode
	assign reg_ch = reg_addr_in[4:2];
	assign reg_region = reg_addr_in[7:5];
	assign ch_ok = {1'b0, reg_ch} < 4'(NCH);
	assign wr_reload = reg_wr_in && reg_addr_in[7:4] == REG_RELOAD_HI && {1'b0, reg_addr_in[3:2]} < 3'(NLOW);
	assign wr_freq = reg_wr_in && reg_region == REGION_FREQ && ch_ok;
	assign wr_pm = reg_wr_in && reg_region == REGION_PERMILLE && ch_ok;
	assign req_ok = state_q == JOB_IDLE;

	// control word: init, lower prescale, upper prescale
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
			ctrl_q <= CTRL_RST;
		else if (reg_wr_in && reg_addr_in == REG_CTRL)
			ctrl_q <= reg_wdata_in[CTRL_W-1:0];

	// raw presets, or those worked out in permille mode
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
		begin
			for (int i = 0; i < NLOW; i++)
				reload_q[i] <= RELOAD_RST;
			up_reload_q <= UP_RELOAD_RST;
		end
		else
		begin
			for (int i = 0; i < NLOW; i++)
				if (wr_reload && reg_addr_in[3:2] == 2'(i))
					reload_q[i] <= reg_wdata_in[15:0];
				else if (div_done && state_q == JOB_FREQ && !job_up && job_ch_q == 3'(i))
					reload_q[i] <= quot_sat;
			if (reg_wr_in && reg_addr_in == REG_UP_RELOAD)
				up_reload_q <= reg_wdata_in[15:0];
			else if (div_done && state_q == JOB_FREQ && job_up)
				up_reload_q <= 16'h0000 - quot_sat;
		end

	// dither amplitude and divider, per channel
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
		begin
			for (int i = 0; i < NCH; i++)
				dither_q[i] <= DITHER_RST;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
				if (reg_wr_in && reg_region == REGION_DITHER && reg_ch == 3'(i))
					dither_q[i] <= reg_wdata_in;
		end

	// duty hand-over: only writes with the change bit reach a channel
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
		begin
			duty_ld_q <= '0;
			for (int i = 0; i < NCH; i++)
				duty_val_q[i] <= DUTY_RST;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
				if (div_done && state_q == JOB_DUTY && job_ch_q == 3'(i))
				begin
					duty_ld_q[i] <= job_chg_q;
					duty_val_q[i] <= pm_cmp;
				end
				else
				begin
					duty_ld_q[i] <= reg_wr_in && reg_region == REGION_DUTY && reg_ch == 3'(i)
						&& reg_wdata_in[DUTY_CHANGE_BIT];
					duty_val_q[i] <= reg_wdata_in[15:0];
				end
		end

	////////////////////////////////////////////////////////////
	// free-running divide-by-64 tick
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
			psc_q <= '0;
		else
			psc_q <= psc_q + 1'b1;

	assign psc_tick = &psc_q;

	// lower group: one down counter per channel
	for (genvar g = 0; g < NLOW; g++)
	begin : g_low
		assign low_run[g] = ctrl_q[CTRL_INIT_LSB + g];
		assign low_tick[g] = ctrl_q[CTRL_PSC_LSB + g] ? psc_tick : 1'b1;
		assign low_rl[g] = (reload_q[g] < min_span(ctrl_q[CTRL_PSC_LSB + g]))
			? min_span(ctrl_q[CTRL_PSC_LSB + g]) : reload_q[g];
		assign low_wrap[g] = low_run[g] && low_tick[g] && low_cnt_q[g] <= 16'h0001;

		always_ff @(posedge clk_sys_in)
			if (!rst_n_in)
				low_cnt_q[g] <= RELOAD_RST;
			else if (!low_run[g] || low_wrap[g])
				low_cnt_q[g] <= low_rl[g];
			else if (low_tick[g])
				low_cnt_q[g] <= low_cnt_q[g] - 16'h0001;

		a_low_down: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
			low_run[g] && low_tick[g] && !low_wrap[g] |=> low_cnt_q[g] == $past(low_cnt_q[g]) - 16'h0001)
			else $error("lower counter did not step down");
		a_low_reload: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
			low_wrap[g] |=> low_cnt_q[g] == $past(low_rl[g]))
			else $error("lower counter not reloaded at wrap");
		a_low_cap: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
			low_run[g] |-> low_cnt_q[g] <= low_rl[g] && low_rl[g] >= 16'(MIN_SPAN_PS))
			else $error("lower span outside clamp");
	end

	// upper group: one shared up counter
	assign up_run = |ctrl_q[CTRL_INIT_LSB + NLOW +: NUP];
	assign up_tick = ctrl_q[CTRL_UPSC_BIT] ? psc_tick : 1'b1;
	assign up_rl = (up_reload_q > 16'h0000 - min_span(ctrl_q[CTRL_UPSC_BIT]))
		? 16'h0000 - min_span(ctrl_q[CTRL_UPSC_BIT]) : up_reload_q;
	assign up_wrap = up_run && up_tick && up_cnt_q == 16'hffff;

	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
			up_cnt_q <= UP_RELOAD_RST;
		else if (!up_run || up_wrap)
			up_cnt_q <= up_rl;
		else if (up_tick)
			up_cnt_q <= up_cnt_q + 16'h0001;

	////////////////////////////////////////////////////////////
	// channels, each tied to its group's counter
	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		if (g < NLOW)
		begin : g_sel
			assign ch_cnt[g] = low_cnt_q[g];
			assign ch_rl[g] = low_rl[g];
			assign ch_wrap[g] = low_wrap[g];
		end
		else
		begin : g_sel
			assign ch_cnt[g] = up_cnt_q;
			assign ch_rl[g] = up_rl;
			assign ch_wrap[g] = up_wrap;
		end

		rcpwm_chan #(
			.UP(g >= NLOW)
		) u_chan (
			.clk_sys_in(clk_sys_in),
			.rst_n_in(rst_n_in),
			.run_in(ctrl_q[CTRL_INIT_LSB + g]),
			.count_in(ch_cnt[g]),
			.wrap_in(ch_wrap[g]),
			.reload_in(ch_rl[g]),
			.duty_in(duty_val_q[g]),
			.duty_load_in(duty_ld_q[g]),
			.dith_amp_in(dither_q[g][15:0]),
			.dith_div_in(dither_q[g][DITH_DIV_LSB +: 16]),
			.pwm_out(pwm_out[g]),
			.cmp_out(ch_cmp[g])
		);
	end

	////////////////////////////////////////////////////////////
	// permille jobs: frequency to preset, permille to compare
	assign job_up = {1'b0, job_ch_q} >= 4'(NLOW);
	assign div_start = (wr_freq || wr_pm) && req_ok;
	assign quot_sat = (|div_quot[31:16]) ? 16'hffff : div_quot[15:0];

	// lower compare = span - on; upper compare = full span - on
	assign pm_diff = (job_up ? 17'h10000 : job_span_q) - {1'b0, quot_sat};
	assign pm_cmp = pm_diff[16] ? 16'hffff : pm_diff[15:0];

	always_comb
	begin
		div_num = 32'h0;
		div_den = 32'h1;
		if (wr_freq)
		begin
			div_num = (reg_ch < 3'(NLOW) ? ctrl_q[CTRL_PSC_LSB + reg_ch] : ctrl_q[CTRL_UPSC_BIT])
				? 32'(CLK_HZ / PRESCALE) : 32'(CLK_HZ);
			div_den = (reg_wdata_in[15:0] == 16'h0000) ? 32'h1 : {16'h0, reg_wdata_in[15:0]};
		end
		else if (wr_pm)
		begin
			// both factors widened first, so the product is never cut to 17 bits
			div_num = {15'h0, (reg_ch < 3'(NLOW)) ? {1'b0, low_rl[reg_ch[1:0]]} : 17'h10000 - {1'b0, up_rl}}
				* {22'h0, (reg_wdata_in[9:0] > 10'(PERMILLE_FULL)) ? 10'(PERMILLE_FULL) : reg_wdata_in[9:0]};
			div_den = 32'(PERMILLE_FULL);
		end
	end

	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
		begin
			state_q <= JOB_IDLE;
			job_ch_q <= 3'h0;
			job_chg_q <= 1'b0;
			job_span_q <= 17'h0;
		end
		else
			unique case (state_q)
				JOB_IDLE:
					if (div_start)
					begin
						state_q <= wr_freq ? JOB_FREQ : JOB_DUTY;
						job_ch_q <= reg_ch;
						job_chg_q <= reg_wdata_in[DUTY_CHANGE_BIT];
						job_span_q <= {1'b0, low_rl[reg_ch[1:0]]};
					end
				JOB_FREQ, JOB_DUTY:
					if (div_done)
						state_q <= JOB_IDLE;
				default:
					state_q <= JOB_IDLE;
			endcase

	// a request while busy is dropped; set wins over clear
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
			refused_q <= 1'b0;
		else if ((wr_freq || wr_pm) && !req_ok)
			refused_q <= 1'b1;
		else if (reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[STAT_REFUSED_BIT])
			refused_q <= 1'b0;

	rcpwm_div #(
		.W(32)
	) u_div (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.start_in(div_start),
		.num_in(div_num),
		.den_in(div_den),
		.busy_out(div_busy),
		.done_out(div_done),
		.quot_out(div_quot)
	);

	////////////////////////////////////////////////////////////
	// read data stands one cycle, zero otherwise
	always_comb
	begin
		rd_mux = 32'h0;
		if (reg_addr_in == REG_CTRL)
			rd_mux = 32'(ctrl_q);
		else if (reg_addr_in == REG_STATUS)
		begin
			rd_mux[STAT_BUSY_BIT] = !req_ok;
			rd_mux[STAT_REFUSED_BIT] = refused_q;
			rd_mux[STAT_OUT_LSB +: NCH] = pwm_out;
		end
		else if (reg_addr_in == REG_UP_RELOAD)
			rd_mux = {16'h0, up_reload_q};
		else if (reg_addr_in[7:4] == REG_RELOAD_HI && {1'b0, reg_addr_in[3:2]} < 3'(NLOW))
			rd_mux = {16'h0, reload_q[reg_addr_in[3:2]]};
		else if (reg_region == REGION_DUTY && ch_ok)
			rd_mux = {16'h0, ch_cmp[reg_ch]};
		else if (reg_region == REGION_DITHER && ch_ok)
			rd_mux = dither_q[reg_ch];
	end

	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
			reg_rdata_out <= 32'h0;
		else
			reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;

	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	a_up_count: assert property (up_run && up_tick && !up_wrap |=> up_cnt_q == $past(up_cnt_q) + 16'h0001)
		else $error("upper counter did not step up");
	a_up_wrap: assert property (up_wrap |=> up_cnt_q == $past(up_rl))
		else $error("upper counter not reloaded at wrap");
	a_up_cap: assert property (up_rl <= 16'h0000 - 16'(MIN_SPAN_PS))
		else $error("upper span below clamp");
	a_job_length: assert property (div_start |-> ##33 div_done)
		else $error("permille job took wrong time");
	a_job_busy: assert property (div_start |=> !req_ok [*8])
		else $error("job state left early");
	c_job_done: cover property (state_q == JOB_DUTY && div_done);
	c_up_wrap: cover property (up_wrap);

endmodule : rcpwm_top

`default_nettype wire

// ---- rcpwm_pkg.sv ----
/*
 rcpwm_pkg: constants, register map and job states of the
 reload-counter pwm block.
 assumes a 125 MHz system clock driving every counter.
*/
`default_nettype none

package rcpwm_pkg;

	// clock and pwm frequency ceiling
	localparam int CLK_PERIOD_NS = 8;
	localparam int CLK_HZ = 125000000;
	localparam int PWM_MIN_PERIOD_NS = 200000; // 5 kHz
	localparam int MIN_SPAN = (PWM_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRESCALE = 64;
	localparam int PSC_W = $clog2(PRESCALE);
	localparam int MIN_SPAN_PS = (MIN_SPAN + PRESCALE - 1) / PRESCALE;
	localparam int PERMILLE_FULL = 1000;

	////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_UP_RELOAD = 8'h08;
	localparam logic [3:0] REG_RELOAD_HI = 4'h1; // 0x10..0x1c
	localparam logic [2:0] REGION_DUTY = 3'h1; // 0x20 + 4*ch
	localparam logic [2:0] REGION_DITHER = 3'h2; // 0x40 + 4*ch
	localparam logic [2:0] REGION_FREQ = 3'h3; // 0x60 + 4*ch
	localparam logic [2:0] REGION_PERMILLE = 3'h4; // 0x80 + 4*ch

	// fields
	localparam int CTRL_W = 13;
	localparam int CTRL_INIT_LSB = 0;
	localparam int CTRL_PSC_LSB = 8;
	localparam int CTRL_UPSC_BIT = 12;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REFUSED_BIT = 1;
	localparam int STAT_OUT_LSB = 8;
	localparam int DUTY_CHANGE_BIT = 16;
	localparam int DITH_DIV_LSB = 16;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
	localparam logic [15:0] RELOAD_RST = 16'hffff;
	localparam logic [15:0] UP_RELOAD_RST = 16'h0000;
	localparam logic [15:0] DUTY_RST = 16'hffff;
	localparam logic [31:0] DITHER_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		JOB_IDLE = 3'b001,
		JOB_FREQ = 3'b010,
		JOB_DUTY = 3'b100
	} rcpwm_job_e;

endpackage : rcpwm_pkg

`default_nettype wire

// ---- rcpwm_div.sv ----
/*
 rcpwm_div: restoring serial divider, one quotient bit per clock.
 assumes start is only raised while busy is low.
*/
`timescale 1ns/1ns
`default_nettype none

module rcpwm_div #(
	parameter int W = 32
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic [W-1:0] num_in,
	input wire logic [W-1:0] den_in,
	output logic busy_out,
	output logic done_out,
	output logic [W-1:0] quot_out
);
	localparam int CW = $clog2(W) + 1;
	logic [W-1:0] rem_q;
	logic [W-1:0] den_q;
	logic [CW-1:0] cnt_q;
	logic [W:0] trial;

	// trial subtract; borrow in the top bit means it does not fit
	assign trial = {rem_q, quot_out[W-1]} - {1'b0, den_q};

	////////////////////////////////////////////////////////////
	// shift and subtract
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
		begin
			busy_out <= 1'b0;
			done_out <= 1'b0;
			cnt_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			quot_out <= '0;
		end
		else
		begin
			done_out <= 1'b0;
			if (start_in && !busy_out)
			begin
				busy_out <= 1'b1;
				cnt_q <= CW'(W);
				rem_q <= '0;
				den_q <= den_in;
				quot_out <= num_in;
			end
			else if (busy_out)
			begin
				rem_q <= trial[W] ? {rem_q[W-2:0], quot_out[W-1]} : trial[W-1:0];
				quot_out <= {quot_out[W-2:0], ~trial[W]};
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == CW'(1))
				begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end

endmodule : rcpwm_div

`default_nettype wire

// ---- rcpwm_chan.sv ----
/*
 rcpwm_chan: one pwm output: duty hand-over, dither and compare.
 assumes count, wrap and effective reload come from the counter
 of its group in the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module rcpwm_chan import rcpwm_pkg::*; #(
	parameter bit UP = 1'b0
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic [15:0] count_in,
	input wire logic wrap_in,
	input wire logic [15:0] reload_in,
	input wire logic [15:0] duty_in,
	input wire logic duty_load_in,
	input wire logic [15:0] dith_amp_in,
	input wire logic [15:0] dith_div_in,
	output logic pwm_out,
	output logic [15:0] cmp_out
);
	logic [15:0] duty_q;
	logic [15:0] pend_q;
	logic pend_v_q;
	logic [15:0] dcnt_q;
	logic dsign_q;
	logic dith_on;
	logic restart;
	logic [15:0] lo;
	logic [15:0] hi;
	logic [16:0] raw;
	logic [15:0] cmp_eff;
	logic active;

	assign dith_on = (dith_amp_in != 16'h0000) && (dith_div_in != 16'h0000);
	assign restart = !run_in || wrap_in;
	assign lo = UP ? reload_in : 16'h0000;
	assign hi = UP ? 16'hffff : reload_in;

	////////////////////////////////////////////////////////////
	// accepted duty waits for a period restart, so no pulse is cut
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
		begin
			duty_q <= DUTY_RST;
			pend_q <= DUTY_RST;
			pend_v_q <= 1'b0;
		end
		else if (duty_load_in && restart)
		begin
			duty_q <= duty_in;
			pend_v_q <= 1'b0;
		end
		else if (duty_load_in)
		begin
			pend_q <= duty_in;
			pend_v_q <= 1'b1;
		end
		else if (pend_v_q && restart)
		begin
			duty_q <= pend_q;
			pend_v_q <= 1'b0;
		end

	// dither sign flips every divider periods: two flips per cycle
	always_ff @(posedge clk_sys_in)
		if (!rst_n_in || !run_in || !dith_on)
		begin
			dcnt_q <= 16'h0000;
			dsign_q <= 1'b0;
		end
		else if (wrap_in && dcnt_q >= dith_div_in - 16'h0001)
		begin
			dcnt_q <= 16'h0000;
			dsign_q <= ~dsign_q;
		end
		else if (wrap_in)
			dcnt_q <= dcnt_q + 16'h0001;

	// offset duty, then clamp into the group's legal span
	always_comb
	begin
		raw = {1'b0, duty_q};
		if (dith_on && dsign_q)
			raw = raw + {1'b0, dith_amp_in};
		else if (dith_on && ({1'b0, duty_q} < {1'b0, dith_amp_in} + {1'b0, lo}))
			raw = {1'b0, lo};
		else if (dith_on)
			raw = raw - {1'b0, dith_amp_in};
		if (raw > {1'b0, hi})
			cmp_eff = hi;
		else if (raw < {1'b0, lo})
			cmp_eff = lo;
		else
			cmp_eff = raw[15:0];
	end

	// up: all-ones never turns on; down: preset never turns on
	assign active = UP ? (cmp_eff != 16'hffff) && (count_in >= cmp_eff) : (count_in > cmp_eff);

	always_ff @(posedge clk_sys_in)
		if (!rst_n_in)
		begin
			pwm_out <= 1'b0;
			cmp_out <= DUTY_RST;
		end
		else
		begin
			pwm_out <= run_in && active;
			cmp_out <= cmp_eff;
		end

	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	a_out_idle: assert property (!run_in |=> !pwm_out) else $error("output on while idle");
	a_full_on: assert property (run_in && cmp_eff == lo |=> pwm_out) else $error("full duty not on");
	a_zero_on: assert property (run_in && cmp_eff == hi |=> !pwm_out) else $error("zero duty not off");
	a_pend_apply: assert property (pend_v_q && wrap_in && !duty_load_in |=> duty_q == $past(pend_q))
		else $error("pending duty not applied at restart");
	a_duty_hold: assert property (!duty_load_in && !pend_v_q |=> duty_q == $past(duty_q))
		else $error("duty changed without strobe");
	a_dither_flip: assert property (run_in && dith_on && wrap_in && dcnt_q == dith_div_in - 16'h0001
		|=> dsign_q != $past(dsign_q)) else $error("dither sign did not flip");
	a_dither_up: assert property (dith_on && dsign_q |-> cmp_eff >= duty_q || cmp_eff == hi)
		else $error("dither raise went down");
	c_pend_wrap: cover property (pend_v_q && wrap_in);
	c_dither_flip: cover property (dith_on && $changed(dsign_q));
	c_pwm_rise: cover property ($rose(pwm_out));

endmodule : rcpwm_chan

`default_nettype wire

// ---- rcpwm_valve.sv ----
/*
 rcpwm_valve: valve load on one pwm output; measures the
 on-time and the period between two rising edges of its drive.
 assumes the drive is registered on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

module rcpwm_valve (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic pwm_in,
	output logic [31:0] hi_out,
	output logic [31:0] per_out,
	output logic valid_out
);
	logic prev_q;
	logic [31:0] hi_cnt_q;
	logic [31:0] per_cnt_q;
	logic [1:0] edges_q;

	////////////////////////////////////////////////////////////
	// the coil only sees the drive level; a full period is rise to rise
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			prev_q <= 1'b0;
			hi_cnt_q <= 32'h0;
			per_cnt_q <= 32'h0;
			edges_q <= 2'h0;
			hi_out <= 32'h0;
			per_out <= 32'h0;
			valid_out <= 1'b0;
		end
		else
		begin
			prev_q <= pwm_in;
			if (pwm_in && !prev_q)
			begin
				hi_out <= hi_cnt_q;
				per_out <= per_cnt_q;
				hi_cnt_q <= 32'h1;
				per_cnt_q <= 32'h1;
				// first rise only starts the count, so it is not a period
				if (edges_q != 2'h2)
					edges_q <= edges_q + 2'h1;
				valid_out <= (edges_q != 2'h0);
			end
			else
			begin
				hi_cnt_q <= hi_cnt_q + {31'h0, pwm_in};
				per_cnt_q <= per_cnt_q + 32'h1;
			end
		end
	end
endmodule : rcpwm_valve

`default_nettype wire

// ---- reload_counter_pwm_with_dither_tb.sv ----
/*
 reload_counter_pwm_with_dither_tb: register-level tests of rcpwm_top
 with valve loads on one lower and one upper channel.
 assumes a single-cycle register master on the 125 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

module reload_counter_pwm_with_dither_tb import rcpwm_pkg::*;;
	logic clk_sys_in;
	logic rst_n_in;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [7:0] pwm;
	logic [31:0] hi0, per0, hi4, per4, v;
	logic ok0, ok4;
	logic p0;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	int err_total;
	int checks;

	rcpwm_top DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pwm_out(pwm));
	rcpwm_valve u_v0 (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .pwm_in(pwm[0]), .hi_out(hi0),
		.per_out(per0), .valid_out(ok0));
	rcpwm_valve u_v4 (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .pwm_in(pwm[4]), .hi_out(hi4),
		.per_out(per4), .valid_out(ok4));

	////////////////////////////////////////////////////////////
	// bus tasks: strobes for one cycle, changed right after the edge
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask : chk

	// read one register and compare the masked word
	task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
		rd_reg(a, v);
		chk(nm, exp, v & m);
	endtask : rd_chk

	task test_done;
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////
	// clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		err_total = 0;
		checks = 0;
		rst_n_in = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (5) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rd_chk(8'h00, ALL, 32'h0, "ctrl");
		rd_chk(8'h10, ALL, 32'hffff, "reload0");
		rd_chk(8'h08, ALL, 32'h0, "up_reload");
		rd_chk(8'hfc, ALL, 32'h0, "unmapped");
		// preset far above 5 kHz must be widened to the ceiling span
		wr_reg(8'h10, 32'h64);
		wr_reg(8'h20, 32'h1_30d4);
		// the compare register trails the strobe by two clocks
		@(posedge clk_sys_in);
		rd_chk(8'h20, ALL, 32'h30d4, "duty0");
		wr_reg(8'h20, 32'h0_1000);
		@(posedge clk_sys_in);
		rd_chk(8'h20, ALL, 32'h30d4, "duty0 no change");
		wr_reg(8'h24, 32'h1_0000);
		// upper preset is full span minus tick over 5 kHz, raw setup only
		wr_reg(8'h08, 32'h9e58);
		wr_reg(8'h30, 32'h1_c568);
		// permille job, second request while busy is refused
		wr_reg(8'h88, 32'h1_01f4);
		wr_reg(8'h88, 32'h1_0064);
		rd_chk(8'h04, 32'h3, 32'h3, "busy refused");
		repeat (40) @(posedge clk_sys_in);
		rd_chk(8'h28, ALL, 32'h8000, "permille duty");
		wr_reg(8'h04, 32'h2);
		rd_chk(8'h04, 32'h3, 32'h0, "refused cleared");
		// 100 Hz lies below the direct range, so the slow tick goes first
		wr_reg(8'h00, 32'h800);
		wr_reg(8'h6c, 32'h64);
		repeat (40) @(posedge clk_sys_in);
		rd_chk(8'h1c, ALL, 32'h4c4b, "freq preset3");
		// upper prescale stays off: 5 kHz is far above its low limit
		wr_reg(8'h00, 32'h33);
		for (int i = 0; i < 80000 && !(ok0 && ok4); i++)
			@(posedge clk_sys_in);
		chk("valves ready", 32'h1, {31'h0, ok0 && ok4});
		if (ok0 && ok4)
		begin
			chk("period0", 32'd25000, per0);
			chk("on0", 32'd12500, hi0);
			chk("period4", 32'd25000, per4);
			chk("on4", 32'd15000, hi4);
			chk("full on", 32'h1, {31'h0, pwm[1]});
			chk("full off", 32'h0, {31'h0, pwm[5]});
			// meet a period start of output 0 so the dither phase is known
			p0 = 1'b1;
			for (int i = 0; i < 30000 && !(pwm[0] && !p0); i++)
			begin
				p0 = pwm[0];
				@(negedge clk_sys_in);
			end
			chk("pwm0 rise", 32'h1, {31'h0, pwm[0] && !p0});
			if (pwm[0] && !p0)
			begin
				wr_reg(8'h40, 32'h0001_1000);
				wr_reg(8'h24, 32'h1_61a8);
				rd_chk(8'h20, ALL, 32'h20d4, "dither low");
				rd_chk(8'h24, ALL, 32'h0, "duty1 pending");
				// one wrap of output 0 flips the sign; output 1 wraps before that, at its own preset
				repeat (25000) @(posedge clk_sys_in);
				rd_chk(8'h20, ALL, 32'h40d4, "dither high");
				rd_chk(8'h24, ALL, 32'h61a8, "duty1 applied");
			end
		end
		test_done();
	end
endmodule : reload_counter_pwm_with_dither_tb

`default_nettype wire
